// ---- acx_axis_comp.sv ----
`timescale 1ns/1ps
`default_nettype none
module acx_axis_comp #(
    parameter int TABLE_POINTS      = 200,
    parameter int ROT_UNITS_PER_DEG = 10000
) (
    input  wire logic                                clk,
    input  wire logic                                reset,
    input  wire logic                                ce,
    input  wire logic                                pos_valid,
    input  wire logic signed [acx_pkg::POS_W-1:0]    pos_raw,
    input  wire logic                                ref_crossed,
    input  wire logic                                enc_rotary,
    input  wire logic                                enc_has_ref,
    input  wire acx_pkg::acx_cfg_s                   cfg_in,
    input  wire logic                                cfg_load,
    input  wire logic                                capture_origin_command,
    input  wire acx_pkg::acx_tbl_wr_s                tbl_wr,
    input  wire logic [acx_pkg::IDX_W-1:0]           tbl_rd_index,
    output var  logic signed [acx_pkg::POS_W-1:0]    comp_pos,
    output var  logic                                comp_valid,
    output var  logic                                comp_active,
    output var  logic signed [acx_pkg::POS_W-1:0]    ref_pos,
    output var  logic signed [acx_pkg::POS_W-1:0]    start_pos,
    output var  logic signed [acx_pkg::ERR_W-1:0]    tbl_rd_data,
    output var  logic                                busy
);

    localparam int POS_W = acx_pkg::POS_W;
    localparam int ERR_W = acx_pkg::ERR_W;
    localparam int IDX_W = acx_pkg::IDX_W;
    localparam int DIV_W = acx_pkg::DIV_W;
    localparam int LIN_W = acx_pkg::LIN_W;
    localparam logic [POS_W-1:0] ROT_SPACING = POS_W'(ROT_UNITS_PER_DEG * acx_pkg::ROT_STEP_DEG);
    localparam logic [IDX_W-1:0] TBL_PTS     = IDX_W'(TABLE_POINTS);

    generate
        if (TABLE_POINTS > acx_pkg::MAX_POINTS || TABLE_POINTS < int'(acx_pkg::ROT_POINTS))
        begin : g_bad_points
            $error("TABLE_POINTS must lie between the rotary point count and 200");
        end
        if (ROT_UNITS_PER_DEG < 1 || ROT_UNITS_PER_DEG > 1000000)
        begin : g_bad_rot
            $error("ROT_UNITS_PER_DEG out of range");
        end
    endgenerate

    acx_pkg::acx_cfg_s   cfg_q;
    acx_pkg::acx_state_e state_q;
    logic signed [POS_W-1:0] pos_q;
    logic [IDX_W-1:0]        idx_q;
    logic [POS_W-1:0]        rem_q;
    logic [POS_W-1:0]        spc_q;
    logic signed [ERR_W-1:0] e0_q;
    logic                    neg_q;
    logic signed [ERR_W-1:0] tbl_q [TABLE_POINTS];

    // Effective table geometry; a rotary axis uses the fixed revolution grid
    wire logic [IDX_W-1:0] npts = enc_rotary ? acx_pkg::ROT_POINTS : cfg_q.points;
    wire logic [POS_W-1:0] spacing = enc_rotary ? ROT_SPACING : cfg_q.spacing;
    wire logic signed [POS_W-1:0] start = enc_rotary ? '0 : cfg_q.start;

    wire logic lin_ok = cfg_q.mode == acx_pkg::ACX_MODE_LINEAR && !enc_rotary;
    wire logic tab_cfg = cfg_q.mode == acx_pkg::ACX_TABLE_CORRECTION_MODE;
    wire logic tab_ok = tab_cfg && enc_has_ref && ref_crossed
        && spacing != '0 && npts >= 8'h02 && npts <= TBL_PTS;

    // Offset from the first point, both measured from the scale reference
    wire logic signed [POS_W:0] offset = (POS_W+1)'(pos_raw) - (POS_W+1)'(start);
    wire logic [40:0] span = 41'(npts - 8'h01) * 41'(spacing);
    wire logic in_span = !offset[POS_W] && 41'(offset[POS_W-1:0]) <= span;

    // Linear correction: pos * factor / 10^7 via a fixed reciprocal
    wire logic signed [LIN_W-1:0] lin_full = LIN_W'(pos_raw)
        * LIN_W'(cfg_q.linear_correction_factor) * acx_pkg::LIN_RECIP;
    wire logic signed [LIN_W-1:0] lin_shr = lin_full >>> acx_pkg::LIN_SHIFT;
    wire logic signed [POS_W-1:0] lin_pos = pos_raw + lin_shr[POS_W-1:0];

    // Table fetch of the two neighbouring points
    wire logic [IDX_W-1:0] idx_n = idx_q + 8'h01;
    wire logic signed [ERR_W-1:0] e0 = (int'(idx_q) < TABLE_POINTS) ? tbl_q[idx_q] : '0;
    wire logic signed [ERR_W-1:0] e1 = (int'(idx_n) < TABLE_POINTS) ? tbl_q[idx_n] : '0;
    wire logic signed [ERR_W:0] diff = (ERR_W+1)'(e1) - (ERR_W+1)'(e0);
    wire logic [ERR_W:0] diff_mag = diff[ERR_W] ? -diff : diff;
    wire logic [DIV_W-1:0] prod = DIV_W'(diff_mag) * DIV_W'(rem_q);

    // Shared divider: index and remainder first, interpolation step second
    wire logic start_div1 = state_q == acx_pkg::ACX_ST_IDLE && pos_valid
        && !lin_ok && tab_ok && in_span;
    wire logic start_div2 = state_q == acx_pkg::ACX_ST_FETCH;
    wire logic div_start = start_div1 || start_div2;
    wire logic [DIV_W-1:0] div_dividend = start_div2 ? prod : DIV_W'(offset[POS_W-1:0]);
    wire logic [DIV_W-1:0] div_divisor = start_div2 ? DIV_W'(spc_q) : DIV_W'(spacing);
    logic                  div_done;
    logic [DIV_W-1:0]      div_quo;
    logic [DIV_W-1:0]      div_rem;

    acx_div #(
        .W          (DIV_W)
    ) u_div (
        .clk        (clk),
        .reset      (reset),
        .ce         (ce),
        .start      (div_start),
        .dividend   (div_dividend),
        .divisor    (div_divisor),
        .done       (div_done),
        .quotient   (div_quo),
        .remainder  (div_rem)
    );

    wire logic signed [ERR_W+1:0] step = signed'({1'b0, div_quo[ERR_W:0]});
    wire logic signed [ERR_W+1:0] interp = (ERR_W+2)'(e0_q) + (neg_q ? -step : step);
    wire logic signed [POS_W-1:0] tab_pos = pos_q + POS_W'(interp);

    // Settings: a load replaces all fields at once; capture only after reference
    wire logic take_origin = capture_origin_command && ref_crossed && !cfg_load;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cfg_q <= acx_pkg::CFG_RST;
        end
        else if (ce)
        begin
            if (cfg_load)
            begin
                cfg_q <= cfg_in;
            end
            else if (take_origin)
            begin
                cfg_q.start <= ref_pos;
            end
        end
    end

    // One register per table entry, written individually by index
    generate
        for (genvar g = 0; g < TABLE_POINTS; g++)
        begin : g_entry
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    tbl_q[g] <= '0;
                end
                else if (ce && tbl_wr.en && tbl_wr.index == IDX_W'(g))
                begin
                    tbl_q[g] <= tbl_wr.point_error_value;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tbl_rd_data <= '0;
        end
        else if (ce)
        begin
            tbl_rd_data <= (int'(tbl_rd_index) < TABLE_POINTS) ? tbl_q[tbl_rd_index] : '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q     <= acx_pkg::ACX_ST_IDLE;
            pos_q       <= '0;
            idx_q       <= '0;
            rem_q       <= '0;
            spc_q       <= '0;
            e0_q        <= '0;
            neg_q       <= 1'b0;
            comp_pos    <= '0;
            comp_valid  <= 1'b0;
            comp_active <= 1'b0;
            ref_pos     <= '0;
            busy        <= 1'b0;
        end
        else if (ce)
        begin
            comp_valid <= 1'b0;
            case (state_q)
                acx_pkg::ACX_ST_IDLE:
                begin
                    if (pos_valid)
                    begin
                        pos_q   <= pos_raw;
                        spc_q   <= spacing;
                        ref_pos <= pos_raw;
                        if (start_div1)
                        begin
                            state_q <= acx_pkg::ACX_ST_DIV1;
                            busy    <= 1'b1;
                        end
                        else
                        begin
                            comp_valid  <= 1'b1;
                            comp_active <= lin_ok || tab_ok;
                            comp_pos    <= lin_ok ? lin_pos : pos_raw;
                        end
                    end
                end
                acx_pkg::ACX_ST_DIV1:
                begin
                    if (div_done)
                    begin
                        idx_q   <= div_quo[IDX_W-1:0];
                        rem_q   <= div_rem[POS_W-1:0];
                        state_q <= acx_pkg::ACX_ST_FETCH;
                    end
                end
                acx_pkg::ACX_ST_FETCH:
                begin
                    e0_q    <= e0;
                    neg_q   <= diff[ERR_W];
                    state_q <= acx_pkg::ACX_ST_DIV2;
                end
                acx_pkg::ACX_ST_DIV2:
                begin
                    if (div_done)
                    begin
                        comp_pos    <= tab_pos;
                        comp_valid  <= 1'b1;
                        comp_active <= 1'b1;
                        busy        <= 1'b0;
                        state_q     <= acx_pkg::ACX_ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= acx_pkg::ACX_ST_IDLE;
                    busy    <= 1'b0;
                end
            endcase
        end
    end

    assign start_pos = cfg_q.start;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    wire logic idle_take = ce && pos_valid && state_q == acx_pkg::ACX_ST_IDLE;

    chk_off_passthru: assert property (idle_take && cfg_q.mode == acx_pkg::ACX_MODE_OFF
            |=> comp_valid && comp_pos == $past(pos_raw) && !comp_active)
        else $error("mode off altered the position");

    chk_rotary_no_linear: assert property (idle_take && enc_rotary
            && cfg_q.mode == acx_pkg::ACX_MODE_LINEAR
            |=> comp_valid && comp_pos == $past(pos_raw) && !comp_active)
        else $error("linear correction applied on rotary axis");

    chk_noref_zero: assert property (idle_take && tab_cfg && !ref_crossed
            |=> comp_valid && comp_pos == $past(pos_raw) && !comp_active)
        else $error("table applied before reference crossed");

    chk_noabs_zero: assert property (idle_take && tab_cfg && !enc_has_ref
            |=> comp_pos == $past(pos_raw) && !comp_active)
        else $error("table applied without reference or absolute encoder");

    chk_zero_factor: assert property (idle_take && lin_ok
            && cfg_q.linear_correction_factor == '0 |=> comp_pos == $past(pos_raw))
        else $error("zero factor changed the position");

    chk_origin_load: assert property (ce && take_origin |=> start_pos == $past(ref_pos))
        else $error("capture did not load the reference position");

    chk_origin_refused: assert property (ce && capture_origin_command && !ref_crossed
            && !cfg_load |=> $stable(start_pos))
        else $error("capture accepted before reference crossed");

    chk_entry_write: assert property (ce && tbl_wr.en && int'(tbl_wr.index) < TABLE_POINTS
            |=> tbl_q[$past(tbl_wr.index)] == $past(tbl_wr.point_error_value))
        else $error("table entry write lost");

    chk_span_zero: assert property (idle_take && tab_ok && !lin_ok && !in_span
            |=> comp_valid && comp_pos == $past(pos_raw))
        else $error("correction outside the table span");

endmodule // acx_axis_comp
`default_nettype wire

// ---- acx_pkg.sv ----
// Behaviour
// - Linear mode scales position by signed factor in 0.1 ppm, (S-M)/M times ten million
// - Mode off passes the raw position through with no correction
// - Linear factor is a decimal value in 0.1 ppm units, reset value zero
// - Linear mode is never applied on a rotary axis
// - Table mode only for encoders with reference marks or absolute position
// - Table mode applies zero correction until reference marks are crossed
// - Table holds at most 200 error entries, indexed by point number
// - Between two points the error is linearly interpolated
// - Rotary axis uses a fixed table of 180 points every 2 degrees
// - Point n lies at start position plus n times spacing
// - Start position is relative to the scale reference point
// - Capture command loads current reference position as start, only after reference crossed
// - New start shifts table point positions, stored errors are kept
// - Reference position output shows uncompensated value ignoring datums
// - Any single table entry can be written by index
// - Whole table can be read out or replaced through the serial side
package acx_pkg;

    localparam int POS_W      = 32;
    localparam int ERR_W      = 16;
    localparam int PPM_W      = 24;
    localparam int IDX_W      = 8;
    localparam int DIV_W      = 49;
    localparam int LIN_W      = 80;
    localparam int LIN_SHIFT  = 44;

    // Linear factor unit is 0.1 ppm, so full scale is ten million
    localparam logic signed [LIN_W-1:0] LIN_UNITS = 80'sh0000_0000_0000_0098_9680;
    localparam logic signed [LIN_W-1:0] LIN_RECIP =
        ((80'sh0000_0000_0000_0000_0001 <<< LIN_SHIFT) + (LIN_UNITS >>> 1)) / LIN_UNITS;

    localparam int MAX_POINTS   = 200;
    localparam logic [IDX_W-1:0] ROT_POINTS = 8'hb4;
    localparam int ROT_STEP_DEG = 2;

    typedef enum logic [1:0] {
        ACX_MODE_OFF    = 2'h0,
        ACX_MODE_LINEAR = 2'h1,
        ACX_TABLE_CORRECTION_MODE = 2'h2
    } acx_mode_e;

    typedef enum logic [1:0] {
        ACX_ST_IDLE  = 2'b00,
        ACX_ST_DIV1  = 2'b01,
        ACX_ST_FETCH = 2'b11,
        ACX_ST_DIV2  = 2'b10
    } acx_state_e;

    typedef struct packed {
        acx_mode_e                 mode;
        logic signed [PPM_W-1:0]   linear_correction_factor;
        logic signed [POS_W-1:0]   start;
        logic        [POS_W-1:0]   spacing;
        logic        [IDX_W-1:0]   points;
    } acx_cfg_s;

    typedef struct packed {
        logic                      en;
        logic        [IDX_W-1:0]   index;
        logic signed [ERR_W-1:0]   point_error_value;
    } acx_tbl_wr_s;

    localparam logic signed [PPM_W-1:0] FACTOR_RST  = 24'sh00_0000;
    localparam logic signed [POS_W-1:0] START_RST   = 32'sh0000_0000;
    localparam logic        [POS_W-1:0] SPACING_RST = 32'h0000_0001;
    localparam logic        [IDX_W-1:0] POINTS_RST  = 8'hc8;
    localparam acx_cfg_s CFG_RST = '{
        mode:                     ACX_MODE_OFF,
        linear_correction_factor: FACTOR_RST,
        start:                    START_RST,
        spacing:                  SPACING_RST,
        points:                   POINTS_RST
    };

endpackage

// ---- acx_div.sv ----
`timescale 1ns/1ps
`default_nettype none
// Unsigned restoring divider, one quotient bit per enabled clock
module acx_div #(
    parameter int W = 49
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output var  logic         done,
    output var  logic [W-1:0] quotient,
    output var  logic [W-1:0] remainder
);

    logic [W-1:0] dvs_q;
    logic [W:0]   rem_q;
    logic [7:0]   cnt_q;
    logic         busy_q;

    generate
        if (W < 2 || W > 255)
        begin : g_bad_w
            $error("divider width W must lie between 2 and 255");
        end
    endgenerate

    wire logic [W:0] shifted = {rem_q[W-1:0], quotient[W-1]};
    wire logic       fits    = shifted >= {1'b0, dvs_q};
    wire logic [W:0] rem_d   = fits ? shifted - {1'b0, dvs_q} : shifted;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dvs_q     <= '0;
            rem_q     <= '0;
            cnt_q     <= '0;
            busy_q    <= 1'b0;
            done      <= 1'b0;
            quotient  <= '0;
            remainder <= '0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (start)
            begin
                dvs_q    <= divisor;
                quotient <= dividend;
                rem_q    <= '0;
                cnt_q    <= 8'(W);
                busy_q   <= 1'b1;
            end
            else if (busy_q)
            begin
                rem_q     <= rem_d;
                quotient  <= {quotient[W-2:0], fits};
                remainder <= rem_d[W-1:0];
                cnt_q     <= cnt_q - 8'h01;
                if (cnt_q == 8'h01)
                begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                end
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    chk_div_exact: assert property (done |-> remainder < dvs_q && !busy_q)
        else $error("divider remainder not below divisor");

endmodule // acx_div
`default_nettype wire

// ---- acx_enc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behavioural position encoder: one strobe per sample, data scrambled between strobes
module acx_enc_model (
    input  wire logic                             clk,
    output var  logic                             pos_valid,
    output var  logic signed [acx_pkg::POS_W-1:0] pos_raw,
    output var  logic                             ref_crossed,
    output var  logic                             enc_rotary,
    output var  logic                             enc_has_ref
);
    initial
    begin
        pos_valid   = 1'b0;
        pos_raw     = 32'sh5a5a_5a5a;
        ref_crossed = 1'b0;
        enc_rotary  = 1'b0;
        enc_has_ref = 1'b0;
    end

    task automatic set_kind(input logic rot, input logic has_ref, input logic crossed);
        @(posedge clk);
        enc_rotary  <= rot;
        enc_has_ref <= has_ref;
        ref_crossed <= crossed;
    endtask

    task automatic send(input logic signed [acx_pkg::POS_W-1:0] p);
        @(posedge clk);
        pos_valid <= 1'b1;
        pos_raw   <= p;
        @(posedge clk);
        pos_valid <= 1'b0;
        // Stale data would hide a design that samples off the strobe
        pos_raw   <= ~p;
    endtask
endmodule // acx_enc_model
`default_nettype wire

// ---- tb_acx_axis_comp.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_acx_axis_comp;
    logic                clk;
    logic                reset;
    logic                ce;
    logic                pos_valid;
    logic signed [31:0]  pos_raw;
    logic                ref_crossed;
    logic                enc_rotary;
    logic                enc_has_ref;
    acx_pkg::acx_cfg_s   cfg_in;
    logic                cfg_load;
    logic                cap;
    acx_pkg::acx_tbl_wr_s tbl_wr;
    logic [7:0]          tbl_rd_index;
    logic signed [31:0]  comp_pos;
    logic                comp_valid;
    logic                comp_active;
    logic signed [31:0]  ref_pos;
    logic signed [31:0]  start_pos;
    logic signed [15:0]  tbl_rd_data;
    logic                busy;
    int                  num_errors;
    int                  n_compared;

    // Table path: two divider runs of 49 steps plus handover cycles
    localparam int TAB_LAT = 2 * acx_pkg::DIV_W + 3;

    acx_axis_comp #(.TABLE_POINTS(200), .ROT_UNITS_PER_DEG(10)) u_acx_axis_comp (
        .clk(clk), .reset(reset), .ce(ce), .pos_valid(pos_valid), .pos_raw(pos_raw),
        .ref_crossed(ref_crossed), .enc_rotary(enc_rotary), .enc_has_ref(enc_has_ref),
        .cfg_in(cfg_in), .cfg_load(cfg_load), .capture_origin_command(cap),
        .tbl_wr(tbl_wr), .tbl_rd_index(tbl_rd_index), .comp_pos(comp_pos),
        .comp_valid(comp_valid), .comp_active(comp_active), .ref_pos(ref_pos),
        .start_pos(start_pos), .tbl_rd_data(tbl_rd_data), .busy(busy)
    );

    acx_enc_model u_acx_enc_model (
        .clk(clk), .pos_valid(pos_valid), .pos_raw(pos_raw), .ref_crossed(ref_crossed),
        .enc_rotary(enc_rotary), .enc_has_ref(enc_has_ref)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_val(input string what, input logic signed [31:0] exp,
                             input logic signed [31:0] got, input bit near);
        n_compared++;
        if (!(got === exp || (near && (got === exp + 1 || got === exp - 1))))
        begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    function automatic logic signed [31:0] lin_exp(input logic signed [31:0] p,
                                                   input logic signed [23:0] f);
        logic signed [79:0] prod;
        prod = p * f;
        return p + 32'(prod / acx_pkg::LIN_UNITS);
    endfunction

    // One sample through the encoder, judged when the answer strobe arrives
    task automatic run(input logic signed [31:0] p, input logic signed [31:0] exp,
                       input logic act, input bit near = 1'b0, input bit tab = 1'b0);
        int i;
        u_acx_enc_model.send(p);
        #1;
        check_val("busy", {31'h0, tab}, {31'h0, busy}, 1'b0);
        for (i = 0; i < 120 && comp_valid !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        if (comp_valid !== 1'b1)
        begin
            num_errors++;
            tally_and_finish();
        end
        else
        begin
            check_val("comp_pos", exp, comp_pos, near);
            check_val("comp_active", {31'h0, act}, {31'h0, comp_active}, 1'b0);
            check_val("latency", tab ? TAB_LAT : 0, i, 1'b0);
            check_val("busy", 32'sh0000_0000, {31'h0, busy}, 1'b0);
        end
    endtask

    task automatic load(input acx_pkg::acx_mode_e m, input logic signed [23:0] f,
                        input logic signed [31:0] st, input logic [31:0] sp);
        @(posedge clk);
        cfg_in   <= '{mode: m, linear_correction_factor: f, start: st, spacing: sp,
                      points: 8'hc8};
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic signed [15:0] v);
        @(posedge clk);
        tbl_wr <= '{en: 1'b1, index: idx, point_error_value: v};
        @(posedge clk);
        tbl_wr.en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic signed [15:0] v);
        @(posedge clk);
        tbl_rd_index <= idx;
        repeat (2) @(posedge clk);
        #1;
        check_val("tbl_rd_data", 32'(v), 32'(tbl_rd_data), 1'b0);
    endtask

    task automatic sc_reset();
        #1;
        check_val("comp_pos", 32'sh0000_0000, comp_pos, 1'b0);
        check_val("start_pos", 32'sh0000_0000, start_pos, 1'b0);
        rd(8'h05, 16'sh0000);
    endtask

    task automatic sc_off();
        run(-32'sh0000_3039, -32'sh0000_3039, 1'b0);
        check_val("ref_pos", -32'sh0000_3039, ref_pos, 1'b0);
    endtask

    task automatic sc_linear();
        load(acx_pkg::ACX_MODE_LINEAR, 24'sh00_03e8, 32'sh0000_0000, 32'h0000_0064);
        run(32'sh0098_9680, lin_exp(32'sh0098_9680, 24'sh00_03e8), 1'b1, 1'b1);
        load(acx_pkg::ACX_MODE_LINEAR, -24'sh00_03e8, 32'sh0000_0000, 32'h0000_0064);
        run(32'sh0098_9680, lin_exp(32'sh0098_9680, -24'sh00_03e8), 1'b1, 1'b1);
        load(acx_pkg::ACX_MODE_LINEAR, 24'sh00_0000, 32'sh0000_0000, 32'h0000_0064);
        run(32'sh0098_9680, 32'sh0098_9680, 1'b1);
        load(acx_pkg::acx_mode_e'(2'h3), 24'sh00_03e8, 32'sh0000_0000, 32'h0000_0064);
        run(32'sh0000_0064, 32'sh0000_0064, 1'b0);
    endtask

    task automatic sc_table_rw();
        wr(8'h00, 16'sh000a);
        wr(8'h01, 16'sh001e);
        wr(8'hb3, 16'sh0028);
        wr(8'hc7, -16'sh0007);
        wr(8'hc8, 16'sh0063);
        rd(8'hc7, -16'sh0007);
        rd(8'hc8, 16'sh0000);
        rd(8'h01, 16'sh001e);
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h02, 16'sh0055);
        ce <= 1'b1;
        rd(8'h02, 16'sh0000);
    endtask

    task automatic sc_table();
        u_acx_enc_model.set_kind(1'b0, 1'b1, 1'b0);
        load(acx_pkg::ACX_TABLE_CORRECTION_MODE, 24'sh00_0000, 32'sh0000_03e8, 32'h0000_0064);
        run(32'sh0000_041a, 32'sh0000_041a, 1'b0);
        u_acx_enc_model.set_kind(1'b0, 1'b1, 1'b1);
        run(32'sh0000_041a, 32'sh0000_042e, 1'b1, 1'b0, 1'b1);
        run(32'sh0000_01f4, 32'sh0000_01f4, 1'b1);
        run(32'sh0000_51a4, 32'sh0000_519d, 1'b1, 1'b0, 1'b1);
        u_acx_enc_model.set_kind(1'b0, 1'b0, 1'b1);
        run(32'sh0000_041a, 32'sh0000_041a, 1'b0);
    endtask

    task automatic sc_start();
        u_acx_enc_model.set_kind(1'b0, 1'b1, 1'b1);
        load(acx_pkg::ACX_TABLE_CORRECTION_MODE, 24'sh00_0000, 32'sh0000_07d0, 32'h0000_0064);
        #1;
        check_val("start_pos", 32'sh0000_07d0, start_pos, 1'b0);
        run(32'sh0000_0802, 32'sh0000_0816, 1'b1, 1'b0, 1'b1);
        run(32'sh0000_0bb8, 32'sh0000_0bb8, 1'b1, 1'b0, 1'b1);
        check_val("ref_pos", 32'sh0000_0bb8, ref_pos, 1'b0);
        @(posedge clk);
        cap <= 1'b1;
        @(posedge clk);
        cap <= 1'b0;
        #1;
        check_val("start_pos", 32'sh0000_0bb8, start_pos, 1'b0);
        u_acx_enc_model.set_kind(1'b0, 1'b1, 1'b0);
        run(32'sh0000_1388, 32'sh0000_1388, 1'b0);
        @(posedge clk);
        cap <= 1'b1;
        @(posedge clk);
        cap <= 1'b0;
        #1;
        check_val("start_pos", 32'sh0000_0bb8, start_pos, 1'b0);
        u_acx_enc_model.set_kind(1'b0, 1'b1, 1'b1);
        run(32'sh0000_0bea, 32'sh0000_0bfe, 1'b1, 1'b0, 1'b1);
    endtask

    task automatic sc_rotary();
        u_acx_enc_model.set_kind(1'b1, 1'b1, 1'b1);
        load(acx_pkg::ACX_MODE_LINEAR, 24'sh00_03e8, 32'sh0000_0000, 32'h0000_0064);
        run(32'sh0098_9680, 32'sh0098_9680, 1'b0);
        load(acx_pkg::ACX_TABLE_CORRECTION_MODE, 24'sh00_0000, 32'sh0000_03e8, 32'h0000_0064);
        run(32'sh0000_000a, 32'sh0000_001e, 1'b1, 1'b0, 1'b1);
        run(32'sh0000_0dfc, 32'sh0000_0e24, 1'b1, 1'b0, 1'b1);
        run(32'sh0000_0dfd, 32'sh0000_0dfd, 1'b1);
    endtask

    initial
    begin
        num_errors   = 0;
        n_compared   = 0;
        reset        = 1'b1;
        ce           = 1'b1;
        cfg_in       = acx_pkg::CFG_RST;
        cfg_load     = 1'b0;
        cap          = 1'b0;
        tbl_wr       = '0;
        tbl_rd_index = 8'h00;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        sc_reset();
        sc_off();
        sc_linear();
        sc_table_rw();
        sc_table();
        sc_start();
        sc_rotary();
        tally_and_finish();
    end
endmodule // tb_acx_axis_comp
`default_nettype wire
